// file: core/nec_defs.vh
// Field positions, reset values, widths and encodings of the numeric exception unit
`ifndef NEC_DEFS_VH
`define NEC_DEFS_VH
`define CW_RESET 16'h037f
`define CW_MASK_LO 0
`define CW_MASK_HI 5
`define CW_PREC_LO 8
`define CW_PREC_HI 9
`define CW_RND_LO 10
`define CW_RND_HI 11
`define CW_INF_BIT 12
`define EXC_INV 0
`define EXC_DEN 1
`define EXC_ZDV 2
`define EXC_OVF 3
`define EXC_UNF 4
`define EXC_PRE 5
`define CMD_NONE 3'h0
`define CMD_LDCW 3'h1
`define CMD_CLEX 3'h2
`define CMD_INIT 3'h3
`define CMD_SETPM 3'h4
`define EXP_W 15
`define SIG_W 64
`define EXP_ONES 15'h7fff
`define FIX_NONE 2'h0
`define FIX_NAN 2'h1
`define FIX_INF 2'h2
`define FIX_DENORM 2'h3
`endif

// file: core/fault_ptr_store.v
// Small register store holding the fault instruction and operand pointers
`timescale 1ns/100ps
`default_nettype none
module fault_ptr_store (
  input wire clk,
  input wire rst_b,
  input wire wr_en,
  input wire [31:0] wr_instr,
  input wire [31:0] wr_oper,
  input wire [10:0] wr_opcode,
  input wire rd_sel,
  output reg [31:0] rd_data,
  output reg [10:0] rd_opcode
);
  reg [31:0] mem_reg [0:1];
  reg [10:0] opc_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_reg[0] <= 32'h0;
      mem_reg[1] <= 32'h0;
      opc_reg <= 11'h0;
      rd_data <= 32'h0;
      rd_opcode <= 11'h0;
    end else begin
      if (wr_en) begin
        mem_reg[0] <= wr_instr;
        mem_reg[1] <= wr_oper;
        opc_reg <= wr_opcode;
      end
      rd_data <= mem_reg[rd_sel];
      rd_opcode <= opc_reg;
    end
  end
endmodule
`default_nettype wire

// file: core/numeric_exception_control.v
// Exception detection, masking, error reporting and control word of the numeric unit
// Functional notes
// [RULE_01] Remainder reports Q0, Q1 or Q2..Q0 by dividend size; others keep prior values
// [RULE_02] Control bits 9..8 select reduced internal precision below 80-bit default
// [RULE_03] Control bits 11..10 select nearest-even, down, up or chop rounding
// [RULE_04] Control bit selects affine signed or projective unsigned infinity closure
// [RULE_05] Six exceptions; unmasked one asserts error output and summary bit
// [RULE_06] Invalid on stack faults, indeterminate forms, NaN operand; masked gives NaN
// [RULE_07] All-ones exponent with non-zero significand is a NaN
// [RULE_08] Overflow flagged on too-large result; masked gives infinity
// [RULE_09] Zero divide on zero divisor and finite non-zero dividend; masked gives infinity
// [RULE_10] Underflow on tiny non-zero result; masked requests gradual denormalisation
// [RULE_11] Denormal operand has minimum exponent and non-zero significand; masked continues
// [RULE_12] Inexact result is rounded per mode and flagged; masked continues
// [RULE_13] Host traps further escape or wait while an unmasked error is pending
// [RULE_14] On error keep faulting instruction address and lowest operand address
// [RULE_15] Error output goes straight to the host, no interrupt controller
// [RULE_16] Captured instruction address points at the first prefix
// [RULE_17] Protected mode captures pointers in its format and saves no opcode
// [RULE_18] Host traps escape on task-switched or emulate flag, wait on task-switched
// [RULE_19] Host traps on operand segment limit faults
// [RULE_20] Control bits 5..0 mask the six exceptions individually
// [RULE_21] Busy asserts when execution begins an instruction
// [RULE_22] Flags and summary stay set until clear or initialise, which drops error; summary also falls once a loaded control word masks the set flags
`timescale 1ns/100ps
`default_nettype none
`include "nec_defs.vh"
module numeric_exception_control (
  input wire clk,
  input wire rst_b,
  input wire [2:0] cmd,
  input wire [15:0] cw_wdata,
  input wire instr_start,
  input wire instr_done,
  input wire [31:0] prefix_addr,
  input wire [31:0] oper_addr,
  input wire oper_present,
  input wire [10:0] opcode,
  input wire op_valid,
  input wire stack_fault,
  input wire indeterminate,
  input wire [`EXP_W-1:0] opa_exp,
  input wire [`SIG_W-1:0] opa_sig,
  input wire [`EXP_W-1:0] opb_exp,
  input wire [`SIG_W-1:0] opb_sig,
  input wire is_divide,
  input wire res_valid,
  input wire res_nonzero,
  input wire res_too_big,
  input wire res_too_small,
  input wire res_inexact,
  input wire rem_valid,
  input wire [2:0] rem_quot,
  input wire rem_lt2,
  input wire rem_lt4,
  input wire ptr_sel,
  output wire [15:0] cw_rdata,
  output reg [5:0] exc_flags,
  output reg error_summary_bit,
  output wire error_n,
  output wire busy,
  output reg [3:0] cond_codes,
  output reg [1:0] fix_action,
  output wire [1:0] precision_mode,
  output wire [1:0] rounding_mode,
  output wire affine_mode,
  output reg protected_mode,
  output wire [31:0] ptr_data,
  output wire [10:0] ptr_opcode
);
  reg [15:0] numeric_control_word;
  reg [5:0] exc_flags_next;
  reg [3:0] cond_next;
  reg [1:0] fix_next;
  reg busy_reg;
  wire [5:0] masks;
  wire [5:0] det;
  wire a_nan;
  wire b_nan;
  wire a_den;
  wire b_den;
  wire zdiv;
  wire clear_cmd;
  wire capture;

  function is_nan;
    input [`EXP_W-1:0] e;
    input [`SIG_W-1:0] s;
    begin
      is_nan = (e == `EXP_ONES) && (s != {`SIG_W{1'b0}}); // see [RULE_07]
    end
  endfunction

  function is_denorm;
    input [`EXP_W-1:0] e;
    input [`SIG_W-1:0] s;
    begin
      is_denorm = (e == {`EXP_W{1'b0}}) && (s != {`SIG_W{1'b0}}); // see [RULE_11]
    end
  endfunction

  assign masks = numeric_control_word[`CW_MASK_HI:`CW_MASK_LO]; // see [RULE_20]
  assign precision_mode = numeric_control_word[`CW_PREC_HI:`CW_PREC_LO]; // see [RULE_02]
  assign rounding_mode = numeric_control_word[`CW_RND_HI:`CW_RND_LO]; // see [RULE_03]
  assign affine_mode = numeric_control_word[`CW_INF_BIT]; // see [RULE_04]
  assign cw_rdata = numeric_control_word;
  assign clear_cmd = (cmd == `CMD_CLEX) || (cmd == `CMD_INIT);

  assign a_nan = is_nan(opa_exp, opa_sig);
  assign b_nan = is_nan(opb_exp, opb_sig);
  assign a_den = is_denorm(opa_exp, opa_sig);
  assign b_den = is_denorm(opb_exp, opb_sig);
  // Zero divisor only with a finite, non-zero dividend
  assign zdiv = is_divide && (opb_exp == {`EXP_W{1'b0}}) && (opb_sig == {`SIG_W{1'b0}})
    && (opa_exp != `EXP_ONES) && (opa_sig != {`SIG_W{1'b0}}); // see [RULE_09]

  assign det[`EXC_INV] = op_valid && (stack_fault || indeterminate || a_nan || b_nan); // see [RULE_06]
  assign det[`EXC_DEN] = op_valid && (a_den || b_den); // see [RULE_11]
  assign det[`EXC_ZDV] = op_valid && zdiv; // see [RULE_09]
  assign det[`EXC_OVF] = res_valid && res_too_big; // see [RULE_08]
  assign det[`EXC_UNF] = res_valid && res_nonzero && res_too_small; // see [RULE_10]
  assign det[`EXC_PRE] = res_valid && res_inexact; // see [RULE_12]

  // New detections win over a clear in the same cycle
  always @* begin
    exc_flags_next = clear_cmd ? 6'h0 : exc_flags; // see [RULE_22]
    exc_flags_next = exc_flags_next | det;
  end

  // Default response steering for masked exceptions, invalid first
  always @* begin
    fix_next = `FIX_NONE;
    if (det[`EXC_INV] && masks[`EXC_INV]) begin
      fix_next = `FIX_NAN; // see [RULE_06]
    end else if ((det[`EXC_ZDV] && masks[`EXC_ZDV]) || (det[`EXC_OVF] && masks[`EXC_OVF])) begin
      fix_next = `FIX_INF; // see [RULE_08] see [RULE_09]
    end else if (det[`EXC_UNF] && masks[`EXC_UNF]) begin
      fix_next = `FIX_DENORM; // see [RULE_10]
    end
  end

  // Remainder quotient bits: C3=Q1, C1=Q0, C0=Q2; smaller dividends keep prior bits
  always @* begin
    cond_next = cond_codes;
    if (rem_valid) begin
      cond_next[2] = 1'b0;
      cond_next[1] = rem_quot[0]; // see [RULE_01]
      if (!rem_lt2) begin
        cond_next[3] = rem_quot[1]; // see [RULE_01]
      end
      if (!rem_lt2 && !rem_lt4) begin
        cond_next[0] = rem_quot[2]; // see [RULE_01]
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      numeric_control_word <= `CW_RESET;
      exc_flags <= 6'h0;
      error_summary_bit <= 1'b0;
      cond_codes <= 4'h0;
      fix_action <= `FIX_NONE;
      busy_reg <= 1'b0;
      protected_mode <= 1'b0;
    end else begin
      exc_flags <= exc_flags_next;
      // Summary tracks any unmasked flag, so it falls with the flags it covers
      error_summary_bit <= |(exc_flags_next & ~masks); // see [RULE_05] see [RULE_22]
      cond_codes <= cond_next;
      fix_action <= fix_next;
      if (cmd == `CMD_LDCW) begin
        numeric_control_word <= cw_wdata;
      end else if (cmd == `CMD_INIT) begin
        numeric_control_word <= `CW_RESET;
      end
      if (cmd == `CMD_SETPM) begin
        protected_mode <= 1'b1;
      end else if (cmd == `CMD_INIT) begin
        protected_mode <= protected_mode;
      end
      if (instr_start) begin
        busy_reg <= 1'b1; // see [RULE_21]
      end else if (instr_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Driven straight to the host pin; the host traps while it is low
  assign error_n = ~error_summary_bit; // see [RULE_15] see [RULE_13]
  assign busy = busy_reg; // see [RULE_21]

  // Pointers refresh on each unmasked error; operand address zero when absent
  assign capture = |(det & ~masks); // see [RULE_14]

  fault_ptr_store u_ptr (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(capture),
    .wr_instr(prefix_addr), // see [RULE_16]
    .wr_oper(oper_present ? oper_addr : 32'h0), // see [RULE_14]
    .wr_opcode(protected_mode ? 11'h0 : opcode), // see [RULE_17]
    .rd_sel(ptr_sel),
    .rd_data(ptr_data),
    .rd_opcode(ptr_opcode)
  );
endmodule
`default_nettype wire

// file: test/host_cpu_model.sv
// Host processor model: raises trap vectors on escape and wait instructions
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  input wire logic clk,
  input wire logic error_n,
  input wire logic esc_issue,
  input wire logic wait_issue,
  input wire logic task_switched_flag,
  input wire logic emulate_flag,
  input wire logic oper_start_over,
  input wire logic oper_tail_over,
  output logic [4:0] trap_vec
);
  // Vector 0 stands for no trap; a trap is shown for one cycle
  always @(posedge clk) begin
    trap_vec <= 5'h00;
    if (esc_issue && oper_tail_over) trap_vec <= 5'h09;
    if (esc_issue && oper_start_over) trap_vec <= 5'h0d;
    if ((esc_issue || wait_issue) && !error_n) trap_vec <= 5'h07;
    if ((esc_issue && emulate_flag) || ((esc_issue || wait_issue) && task_switched_flag)) begin
      trap_vec <= 5'h07;
    end
  end
endmodule
`default_nettype wire

// file: test/nec_chk_sva.sv
// Port checker for the numeric exception unit
`timescale 1ns/100ps
`default_nettype none
`include "nec_defs.vh"
module nec_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] cmd,
  input wire logic [15:0] cw_wdata,
  input wire logic instr_start,
  input wire logic op_valid,
  input wire logic res_valid,
  input wire logic rem_valid,
  input wire logic [2:0] rem_quot,
  input wire logic rem_lt2,
  input wire logic [15:0] cw_rdata,
  input wire logic [5:0] exc_flags,
  input wire logic error_summary_bit,
  input wire logic error_n,
  input wire logic busy,
  input wire logic [3:0] cond_codes,
  input wire logic [1:0] precision_mode,
  input wire logic [1:0] rounding_mode,
  input wire logic affine_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence clr_s;
    cmd == `CMD_CLEX && !op_valid && !res_valid;
  endsequence
  err_pin_a: assert property (error_n != error_summary_bit) else $error("error pin");
  sum_mask_a: assert property ($stable(exc_flags) && $stable(cw_rdata) |->
    error_summary_bit == |(exc_flags & ~cw_rdata[5:0])) else $error("summary");
  flag_clear_a: assert property (clr_s |=> exc_flags == 6'h00 && error_n)
    else $error("clear");
  flag_sticky_a: assert property (cmd != `CMD_CLEX && cmd != `CMD_INIT |=>
    (exc_flags & $past(exc_flags)) == $past(exc_flags)) else $error("sticky");
  busy_start_a: assert property (instr_start |=> busy) else $error("busy");
  mode_map_a: assert property ({affine_mode, rounding_mode, precision_mode} ==
    cw_rdata[12:8]) else $error("modes");
  cw_load_a: assert property (cmd == `CMD_LDCW |=> cw_rdata == $past(cw_wdata))
    else $error("load");
  rem_low_a: assert property (rem_valid && rem_lt2 |=> cond_codes[1] == $past(rem_quot[0])
    && cond_codes[3] == $past(cond_codes[3]) && cond_codes[0] == $past(cond_codes[0]))
    else $error("remainder");
endmodule
`default_nettype wire

// file: test/numeric_exception_control_tb.sv
// Self-checking bench for the numeric exception unit
`timescale 1ns/100ps
`default_nettype none
`include "nec_defs.vh"
module numeric_exception_control_tb;
  logic clk, rst_b, instr_start, instr_done, oper_present, op_valid, stack_fault, indeterminate;
  logic is_divide, res_valid, res_nonzero, res_too_big, res_too_small, res_inexact, rem_valid;
  logic rem_lt2, rem_lt4, ptr_sel, error_summary_bit, error_n, busy, affine_mode, protected_mode;
  logic esc_issue, wait_issue, task_switched_flag, emulate_flag, oper_start_over, oper_tail_over;
  logic [2:0] cmd, rem_quot;
  logic [15:0] cw_wdata, cw_rdata;
  logic [31:0] prefix_addr, oper_addr, ptr_data;
  logic [10:0] opcode, ptr_opcode;
  logic [14:0] opa_exp, opb_exp;
  logic [63:0] opa_sig, opb_sig;
  logic [5:0] exc_flags;
  logic [3:0] cond_codes;
  logic [1:0] fix_action, precision_mode, rounding_mode;
  logic [4:0] trap_vec;
  logic [11:0] fx = 12'h3a1;
  logic [11:0] ce = 12'hb93;
  logic [8:0] rq = 9'o125;
  int failures, total_checks, cycles, k;
  numeric_exception_control u_dut (.*);
  host_cpu_model u_host (.*);
  task tick;
    @(posedge clk);
    #1;
  endtask
  task clr;
    {cmd, instr_start, instr_done, op_valid, stack_fault, indeterminate, opa_exp, opa_sig,
      opb_exp, opb_sig, is_divide, res_valid, res_nonzero, res_too_big, res_too_small,
      res_inexact, rem_valid, rem_lt2, rem_lt4, esc_issue, wait_issue, task_switched_flag,
      emulate_flag, oper_start_over, oper_tail_over} = '0;
  endtask
  task go;
    tick;
    clr;
  endtask
  task do_cmd(input logic [2:0] c, input logic [15:0] w);
    tick;
    {cmd, cw_wdata} = {c, w};
    go;
  endtask
  task nan_op;
    tick;
    {opa_exp, opa_sig, op_valid} = {`EXP_ONES, 64'h1, 1'b1};
    go;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask
  task test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Ceiling is many times the expected run so a hang cannot go unseen
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    rst_b = 1'b0;
    clr;
    {ptr_sel, cw_wdata, rem_quot} = '0;
    {prefix_addr, oper_addr, oper_present, opcode} = {32'h0001_2340, 32'h0005_6788, 1'b1, 11'h5a5};
    repeat (5) tick;
    rst_b = 1'b1;
    chk("cw", 16'h037f, cw_rdata);
    chk("err", 1, error_n);
    $display("reset test end");
    for (k = 0; k < 6; k++) begin
      tick;
      case (k)
        0: stack_fault = 1'b1;
        1: opa_sig = 64'h1;
        2: {opa_exp, opa_sig, is_divide} = {15'h3fff, 64'h8000_0000_0000_0000, 1'b1};
        3: res_too_big = 1'b1;
        4: {res_too_small, res_nonzero} = 2'b11;
        default: res_inexact = 1'b1;
      endcase
      {op_valid, res_valid} = (k < 3) ? 2'b10 : 2'b01;
      go;
      chk("flags", 32'h1 << k, exc_flags);
      chk("fix", fx[2*k+:2], fix_action);
      chk("err", 1, error_n);
      do_cmd(`CMD_CLEX, 16'h0000);
    end
    $display("masked test end");
    do_cmd(`CMD_LDCW, 16'h037e);
    nan_op;
    chk("nan", 6'h01, exc_flags);
    chk("err", 0, error_n);
    tick;
    esc_issue = 1'b1;
    go;
    chk("trap", 7, trap_vec);
    chk("iptr", 32'h0001_2340, ptr_data);
    ptr_sel = 1'b1;
    tick;
    chk("optr", 32'h0005_6788, ptr_data);
    chk("opc", 11'h5a5, ptr_opcode);
    do_cmd(`CMD_CLEX, 16'h0000);
    chk("clex", 1, error_n);
    do_cmd(`CMD_SETPM, 16'h0000);
    chk("pm", 1, protected_mode);
    nan_op;
    tick;
    chk("pm opc", 0, ptr_opcode);
    do_cmd(`CMD_INIT, 16'h0000);
    chk("init", {16'h037f, 6'h00}, {cw_rdata, exc_flags});
    chk("init pm", 1, protected_mode);
    $display("error test end");
    for (k = 0; k < 4; k++) begin
      do_cmd(`CMD_LDCW, {3'h0, k[0], k[1:0], k[1:0], 8'h7f});
      chk("modes", {k[0], k[1:0], k[1:0]}, {affine_mode, rounding_mode, precision_mode});
    end
    tick;
    {task_switched_flag, wait_issue} = 2'b11;
    go;
    chk("ts trap", 7, trap_vec);
    tick;
    {emulate_flag, wait_issue} = 2'b11;
    go;
    chk("em wait", 0, trap_vec);
    tick;
    {esc_issue, oper_tail_over} = 2'b11;
    go;
    chk("seg tail", 9, trap_vec);
    tick;
    {esc_issue, oper_start_over} = 2'b11;
    go;
    chk("seg start", 13, trap_vec);
    tick;
    instr_start = 1'b1;
    go;
    chk("busy", 1, busy);
    instr_done = 1'b1;
    go;
    chk("idle", 0, busy);
    for (k = 0; k < 3; k++) begin
      tick;
      {rem_valid, rem_lt4, rem_lt2, rem_quot} = {1'b1, k != 0, k == 2, rq[3*k+:3]};
      go;
      chk("cc", ce[4*k+:4], cond_codes);
    end
    $display("mode test end");
    test_done;
  end
endmodule
bind numeric_exception_control nec_chk u_chk (.*);
`default_nettype wire
